// ---- logic/vseq_pkg.sv ----
// constants and helpers shared by the video sequencer register bank
package vseq_pkg;
  // ------------------------------------------------------------
  // io port addresses
  // ------------------------------------------------------------
  localparam logic [15:0] PORT_STATUS_A = 16'h03c2;
  localparam logic [15:0] PORT_GEN_OUT_WR = 16'h03c2;
  localparam logic [15:0] PORT_GEN_OUT_RD = 16'h03cc;
  localparam logic [15:0] PORT_DECODE_CTRL = 16'h03c3;
  localparam logic [15:0] PORT_SEQ_INDEX = 16'h03c4;
  localparam logic [15:0] PORT_SEQ_DATA = 16'h03c5;
  localparam logic [15:0] PORT_FEATURE_RD = 16'h03ca;
  localparam logic [15:0] PORT_STATUS_B_MONO = 16'h03ba;
  localparam logic [15:0] PORT_STATUS_B_COLOR = 16'h03da;
  // ------------------------------------------------------------
  // sequencer indices
  // ------------------------------------------------------------
  localparam logic [2:0] IDX_HALT = 3'h0;
  localparam logic [2:0] IDX_CLOCKING = 3'h1;
  localparam logic [2:0] IDX_PLANE_WE = 3'h2;
  localparam logic [2:0] IDX_FONT_SEL = 3'h3;
  localparam logic [2:0] IDX_MEM_MODE = 3'h4;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int GO_PORT_BASE = 0;
  localparam int GO_BUF_DEC = 1;
  localparam int GO_CLK_LO = 2;
  localparam int GO_HSYNC_NEG = 6;
  localparam int GO_VSYNC_NEG = 7;
  localparam int SA_SENSE = 4;
  localparam int SA_IRQ = 7;
  localparam int SB_DISP_OFF = 0;
  localparam int SB_VRETRACE = 3;
  localparam int DC_ENABLE = 0;
  localparam int HALT_ASYNC = 0;
  localparam int HALT_SYNC = 1;
  localparam int CM_DOTS8 = 0;
  localparam int CM_LOAD2 = 2;
  localparam int CM_DIV2 = 3;
  localparam int CM_LOAD4 = 4;
  localparam int CM_BLANK = 5;
  localparam int MM_LARGE = 1;
  // ------------------------------------------------------------
  // reset values and encodings
  // ------------------------------------------------------------
  localparam logic [7:0] RST_GEN_OUT = 8'h00;
  localparam logic [7:0] RST_DECODE = 8'h01;
  localparam logic [7:0] RST_HALT = 8'h03;
  localparam logic [7:0] RST_CLOCKING = 8'h00;
  localparam logic [7:0] RST_PLANE_WE = 8'h0f;
  localparam logic [7:0] RST_FONT = 8'h00;
  localparam logic [7:0] RST_MEM_MODE = 8'h00;
  localparam logic [7:0] RST_FEATURE = 8'h00;
  localparam logic [1:0] CLK_SRC_25M = 2'h0;
  localparam logic [1:0] CLK_SRC_28M = 2'h1;
  localparam logic [1:0] CLK_SRC_EXT = 2'h2;
  localparam logic [9:0] LINES_400 = 10'h190;
  localparam logic [9:0] LINES_350 = 10'h15e;
  localparam logic [9:0] LINES_480 = 10'h1e0;
  localparam logic [7:0] DUP_CODE_LO = 8'hc0;
  localparam logic [7:0] DUP_CODE_HI = 8'hdf;
  localparam logic [3:0] DOT_LAST_8 = 4'h7;
  localparam logic [3:0] DOT_LAST_9 = 4'h8;

  // 3-bit bank code to physical 8KB block number in map 2
  function automatic logic [2:0] font_block(input logic [2:0] code);
    font_block = {code[1:0], code[2]};
  endfunction
endpackage

// ---- logic/seq_cfg_if.sv ----
// configuration and timing strobes passed inside the sequencer
`timescale 1ns/1ps
interface seq_cfg_if;
  logic run;
  logic sync_hold;
  logic async_clr;
  logic div2;
  logic dots8;
  logic load2;
  logic load4;
  logic large_mem;
  logic [2:0] bank_a;
  logic [2:0] bank_b;
  logic char_tick;
  logic ser_load;
  modport ctrl (output run, sync_hold, async_clr, div2, dots8, load2,
    load4, large_mem, bank_a, bank_b, input char_tick, ser_load);
  modport timing (input run, sync_hold, async_clr, div2, dots8, load2,
    load4, output char_tick, ser_load);
  modport font (input dots8, large_mem, bank_a, bank_b);
endinterface

// ---- logic/dot_timing.sv ----
// dot, character and serializer load timing of the sequencer
`timescale 1ns/1ps
module dot_timing
  import vseq_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  seq_cfg_if.timing cfg
);
  logic phase_r;
  logic [3:0] dot_r;
  logic [1:0] load_r;
  logic char_tick_r;
  logic ser_load_r;
  logic halted_r;
  wire dot_en = !cfg.div2 || phase_r;
  wire [3:0] dot_last = cfg.dots8 ? DOT_LAST_8 : DOT_LAST_9;
  wire at_char_end = dot_en && (dot_r == dot_last);
  // sync halt waits for the character boundary so no data is lost
  wire hold = cfg.sync_hold && (at_char_end || halted_r);
  wire [1:0] load_mask = cfg.load4 ? 2'h3 : (cfg.load2 ? 2'h1 : 2'h0);

  // the async halt clears this same cycle, mid-character
  always_ff @(posedge clk_in) begin
    if (!rstn_in || cfg.async_clr || hold) begin
      phase_r <= 1'b0;
      dot_r <= 4'h0;
      load_r <= 2'h0;
      char_tick_r <= 1'b0;
      ser_load_r <= 1'b0;
      halted_r <= rstn_in;
    end else begin
      halted_r <= 1'b0;
      phase_r <= !phase_r;
      char_tick_r <= at_char_end;
      ser_load_r <= at_char_end && ((load_r & load_mask) == 2'h0);
      if (dot_en) begin
        dot_r <= at_char_end ? 4'h0 : dot_r + 4'h1;
      end
      if (at_char_end) begin
        load_r <= load_r + 2'h1;
      end
    end
  end
  assign cfg.char_tick = char_tick_r;
  assign cfg.ser_load = ser_load_r;
endmodule

// ---- logic/font_locator.sv ----
// font bank block selection and ninth-dot generation
`timescale 1ns/1ps
module font_locator
  import vseq_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  seq_cfg_if.font cfg,
  input wire logic alpha_mode_in,
  input wire logic attr_b3_in,
  input wire logic [7:0] char_code_in,
  input wire logic dot8_in,
  output logic [2:0] block_out,
  output logic dot9_out
);
  wire use_a = !alpha_mode_in || attr_b3_in;
  wire [2:0] code = use_a ? cfg.bank_a : cfg.bank_b;
  // without the large memory span both banks fall back to block 0
  wire [2:0] block_nxt = cfg.large_mem ? font_block(code) : 3'h0;
  wire dup = char_code_in >= DUP_CODE_LO && char_code_in <= DUP_CODE_HI;
  wire dot9_nxt = !cfg.dots8 && dup && dot8_in;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      block_out <= 3'h0;
      dot9_out <= 1'b0;
    end else begin
      block_out <= block_nxt;
      dot9_out <= dot9_nxt;
    end
  end
endmodule

// ---- logic/vseq_regs.sv ----
// general and sequencer register bank of the video subsystem
//
// Summary of operation
// - clock field picks 25M, 28M or external
// - sync polarity bits code vertical line count
// - buffer decode bit off drops display accesses
// - port base bit moves status B and feature write ports
// - status A shows pending retrace irq, sense
// - status B bit 3 high during vertical retrace
// - status B bit 0 is inverted display enable
// - feature register: write 3?A, read 3CA, inert
// - subsystem enable gates io and memory decode, except its own port
// - index port selects sequencer data register
// - sync halt bit clears at character boundary
// - async halt bit clears sequencer immediately
// - blank bit blanks picture, keeps sync
// - serializer loads every 1, 2 or 4 chars
// - dot clock bit halves master clock
// - 8 or 9 dot chars, ninth copies eighth for codes C0-DF
// - plane mask enables writes per map
// - attribute bit 3 chooses font bank A or B
// - bank A block from bits 5,3,2
// - bank B block from bits 4,1,0
// - bank B code maps like bank A
// - large memory bit required for bank choice
// - bits 7/6 set choose negative vertical/horizontal sync
`timescale 1ns/1ps
module vseq_regs
  import vseq_pkg::*;
#(
  parameter int IDX_W = 3,
  parameter int PLANES = 4
)(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // host io port access
  input wire logic [15:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  output logic io_ack_out,
  // host memory access to the display buffer
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  output logic [PLANES-1:0] plane_wr_out,
  output logic mem_ack_out,
  // status inputs from the display timing
  input wire logic frame_irq_pending_in,
  input wire logic mon_sense_in,
  input wire logic vretrace_in,
  input wire logic disp_en_in,
  // character path inputs
  input wire logic alpha_mode_in,
  input wire logic attr_b3_in,
  input wire logic [7:0] char_code_in,
  input wire logic dot8_in,
  // clock and frame configuration
  output logic [1:0] clk_src_out,
  output logic clk_ext_sel_out,
  output logic clk_sel_bad_out,
  output logic [9:0] vert_lines_out,
  output logic vsync_pos_out,
  output logic hsync_pos_out,
  output logic crt_color_base_out,
  // sequencer state and timing
  output logic seq_run_out,
  output logic blank_out,
  output logic sys_bw_max_out,
  output logic char_tick_out,
  output logic ser_load_out,
  // font path
  output logic [2:0] font_block_out,
  output logic dot9_out
);
  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (IDX_W != 3 || PLANES != 4) begin : g_bad_param
    $error("vseq_regs supports only IDX_W 3 and PLANES 4");
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] gen_out_r;
  logic [7:0] decode_ctrl_r;
  logic [IDX_W-1:0] seq_index_r;
  logic [7:0] feature_r;
  logic [7:0] halt_r;
  logic [7:0] clocking_r;
  logic [7:0] plane_we_r;
  logic [7:0] font_sel_r;
  logic [7:0] mem_mode_r;
  logic [7:0] rdata_nxt;
  logic rd_hit;

  seq_cfg_if cfg();

  // ------------------------------------------------------------
  // port decode
  // ------------------------------------------------------------
  wire dec_on = decode_ctrl_r[DC_ENABLE];
  wire [15:0] port_b = gen_out_r[GO_PORT_BASE] ?
    PORT_STATUS_B_COLOR : PORT_STATUS_B_MONO;
  // the enable register itself stays reachable while decode is off
  wire sel_dc = io_addr_in == PORT_DECODE_CTRL;
  wire sel_go_wr = dec_on && io_addr_in == PORT_GEN_OUT_WR;
  wire sel_go_rd = dec_on && io_addr_in == PORT_GEN_OUT_RD;
  wire sel_sa = dec_on && io_addr_in == PORT_STATUS_A;
  wire sel_idx = dec_on && io_addr_in == PORT_SEQ_INDEX;
  wire sel_dat = dec_on && io_addr_in == PORT_SEQ_DATA;
  wire sel_ft_rd = dec_on && io_addr_in == PORT_FEATURE_RD;
  wire sel_sb = dec_on && io_addr_in == port_b;
  wire wr_go = io_wr_in && sel_go_wr;
  wire wr_dc = io_wr_in && sel_dc;
  wire wr_idx = io_wr_in && sel_idx;
  wire wr_ft = io_wr_in && sel_sb;
  wire wr_dat = io_wr_in && sel_dat;
  wire wr_halt = wr_dat && seq_index_r == IDX_HALT;
  wire wr_clk = wr_dat && seq_index_r == IDX_CLOCKING;
  wire wr_pwe = wr_dat && seq_index_r == IDX_PLANE_WE;
  wire wr_font = wr_dat && seq_index_r == IDX_FONT_SEL;
  wire wr_mm = wr_dat && seq_index_r == IDX_MEM_MODE;

  // ------------------------------------------------------------
  // status words
  // ------------------------------------------------------------
  // live inputs are sampled on the read, so software sees them now
  wire [7:0] status_a = {frame_irq_pending_in, 2'h0,
    mon_sense_in, 4'h0};
  wire [7:0] status_b = {4'h0, vretrace_in, 2'h0,
    !disp_en_in};

  // sequencer data read, unmapped indices read zero
  logic [7:0] seq_rd;
  always_comb begin
    case (seq_index_r)
      IDX_HALT: seq_rd = {6'h00, halt_r[1:0]};
      IDX_CLOCKING: seq_rd = {2'h0, clocking_r[5:2], 1'b0,
        clocking_r[0]};
      IDX_PLANE_WE: seq_rd = {4'h0, plane_we_r[3:0]};
      IDX_FONT_SEL: seq_rd = {2'h0, font_sel_r[5:0]};
      IDX_MEM_MODE: seq_rd = {4'h0, mem_mode_r[3:1], 1'b0};
      default: seq_rd = 8'h00;
    endcase
  end

  always_comb begin
    rdata_nxt = 8'h00;
    rd_hit = 1'b1;
    if (sel_dc) begin
      rdata_nxt = {7'h00, decode_ctrl_r[DC_ENABLE]};
    end else if (sel_go_rd) begin
      rdata_nxt = {gen_out_r[7:6], 2'h0, gen_out_r[3:0]};
    end else if (sel_sa) begin
      rdata_nxt = status_a;
    end else if (sel_sb) begin
      rdata_nxt = status_b;
    end else if (sel_ft_rd) begin
      rdata_nxt = 8'h00;
    end else if (sel_idx) begin
      rdata_nxt = {5'h00, seq_index_r};
    end else if (sel_dat) begin
      rdata_nxt = seq_rd;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      gen_out_r <= RST_GEN_OUT;
      decode_ctrl_r <= RST_DECODE;
      feature_r <= RST_FEATURE;
    end else begin
      if (wr_go) begin
        gen_out_r <= io_wdata_in;
      end
      if (wr_dc) begin
        decode_ctrl_r <= io_wdata_in;
      end
      if (wr_ft) begin
        feature_r <= io_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      seq_index_r <= IDX_HALT;
    end else if (wr_idx) begin
      seq_index_r <= io_wdata_in[IDX_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      halt_r <= RST_HALT;
      clocking_r <= RST_CLOCKING;
      plane_we_r <= RST_PLANE_WE;
      font_sel_r <= RST_FONT;
      mem_mode_r <= RST_MEM_MODE;
    end else begin
      if (wr_halt) begin
        halt_r <= io_wdata_in;
      end
      if (wr_clk) begin
        clocking_r <= io_wdata_in;
      end
      if (wr_pwe) begin
        plane_we_r <= io_wdata_in;
      end
      if (wr_font) begin
        font_sel_r <= io_wdata_in;
      end
      if (wr_mm) begin
        mem_mode_r <= io_wdata_in;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration to the sequencer
  // ------------------------------------------------------------
  wire run_nxt = halt_r[HALT_SYNC] && halt_r[HALT_ASYNC];
  assign cfg.run = run_nxt;
  assign cfg.sync_hold = !halt_r[HALT_SYNC];
  // unregistered so the clear lands in the cycle after the write
  assign cfg.async_clr = !halt_r[HALT_ASYNC];
  assign cfg.div2 = clocking_r[CM_DIV2];
  assign cfg.dots8 = clocking_r[CM_DOTS8];
  assign cfg.load2 = clocking_r[CM_LOAD2];
  assign cfg.load4 = clocking_r[CM_LOAD4];
  assign cfg.large_mem = mem_mode_r[MM_LARGE];
  assign cfg.bank_a = {font_sel_r[5], font_sel_r[3:2]};
  assign cfg.bank_b = {font_sel_r[4], font_sel_r[1:0]};

  dot_timing u_timing (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .cfg(cfg.timing)
  );

  font_locator u_font (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .cfg(cfg.font),
    .alpha_mode_in(alpha_mode_in),
    .attr_b3_in(attr_b3_in),
    .char_code_in(char_code_in),
    .dot8_in(dot8_in),
    .block_out(font_block_out),
    .dot9_out(dot9_out)
  );

  // ------------------------------------------------------------
  // derived configuration outputs
  // ------------------------------------------------------------
  wire [1:0] clk_code = gen_out_r[GO_CLK_LO+1:GO_CLK_LO];
  wire [1:0] size_code = gen_out_r[GO_VSYNC_NEG:GO_HSYNC_NEG];
  logic [9:0] lines_nxt;
  always_comb begin
    case (size_code)
      2'h1: lines_nxt = LINES_400;
      2'h2: lines_nxt = LINES_350;
      2'h3: lines_nxt = LINES_480;
      default: lines_nxt = 10'h000;
    endcase
  end
  // display buffer decode needs both the subsystem and buffer enables
  wire mem_on = dec_on && gen_out_r[GO_BUF_DEC];
  wire [PLANES-1:0] pwe_nxt = {PLANES{mem_wr_in && mem_on}} &
    plane_we_r[PLANES-1:0];

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      io_rdata_out <= 8'h00;
      io_ack_out <= 1'b0;
      plane_wr_out <= '0;
      mem_ack_out <= 1'b0;
    end else begin
      io_rdata_out <= (io_rd_in && rd_hit) ? rdata_nxt : 8'h00;
      io_ack_out <= (io_rd_in && rd_hit) ||
        (io_wr_in && (wr_go || wr_dc || wr_idx || wr_ft || wr_dat));
      plane_wr_out <= pwe_nxt;
      mem_ack_out <= (mem_wr_in || mem_rd_in) && mem_on;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      clk_src_out <= CLK_SRC_25M;
      clk_ext_sel_out <= 1'b0;
      clk_sel_bad_out <= 1'b0;
      vert_lines_out <= 10'h000;
      vsync_pos_out <= 1'b1;
      hsync_pos_out <= 1'b1;
      crt_color_base_out <= 1'b0;
    end else begin
      clk_src_out <= clk_code;
      clk_ext_sel_out <= clk_code == CLK_SRC_EXT;
      clk_sel_bad_out <= clk_code == 2'h3;
      vert_lines_out <= lines_nxt;
      vsync_pos_out <= !gen_out_r[GO_VSYNC_NEG];
      hsync_pos_out <= !gen_out_r[GO_HSYNC_NEG];
      crt_color_base_out <= gen_out_r[GO_PORT_BASE];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      seq_run_out <= 1'b0;
      blank_out <= 1'b0;
      sys_bw_max_out <= 1'b0;
      char_tick_out <= 1'b0;
      ser_load_out <= 1'b0;
    end else begin
      seq_run_out <= run_nxt;
      // blanking leaves the timing counters, and so sync, running
      blank_out <= clocking_r[CM_BLANK];
      sys_bw_max_out <= clocking_r[CM_BLANK];
      char_tick_out <= cfg.char_tick;
      ser_load_out <= cfg.ser_load;
    end
  end
endmodule

// ---- tb/vseq_regs_monitor.sv ----
// assertion checker for the video sequencer register bank
`timescale 1ns/1ps
module vseq_regs_monitor
  import vseq_pkg::*;
#(
  parameter int PLANES = 4
)(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // host side
  input wire logic [15:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic io_ack_out,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  input wire logic [PLANES-1:0] plane_wr_out,
  input wire logic mem_ack_out,
  // status levels
  input wire logic frame_irq_pending_in,
  input wire logic mon_sense_in,
  input wire logic vretrace_in,
  input wire logic disp_en_in,
  // configuration and timing
  input wire logic [1:0] clk_src_out,
  input wire logic clk_ext_sel_out,
  input wire logic clk_sel_bad_out,
  input wire logic [9:0] vert_lines_out,
  input wire logic vsync_pos_out,
  input wire logic hsync_pos_out,
  input wire logic crt_color_base_out,
  input wire logic blank_out,
  input wire logic sys_bw_max_out,
  input wire logic char_tick_out,
  input wire logic ser_load_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  chk_ack_has_req: assert property (
    io_ack_out |-> $past(io_wr_in || io_rd_in)) else $error("stray io ack");
  chk_rdata_idle: assert property (
    !io_ack_out |-> io_rdata_out == 8'h00) else $error("rdata without ack");
  chk_status_a_read: assert property (
    (io_rd_in && io_addr_in == PORT_STATUS_A) ##1 io_ack_out |->
    io_rdata_out == {$past(frame_irq_pending_in), 2'b00,
    $past(mon_sense_in), 4'h0}) else $error("status a wrong");
  chk_status_b_read: assert property (
    (io_rd_in && io_addr_in == (crt_color_base_out ? PORT_STATUS_B_COLOR :
    PORT_STATUS_B_MONO)) ##1 io_ack_out |-> io_rdata_out == {4'h0,
    $past(vretrace_in), 2'b00, !$past(disp_en_in)})
    else $error("status b wrong");
  chk_mem_claim: assert property (
    mem_ack_out |-> $past(mem_wr_in || mem_rd_in)) else $error("stray mem ack");
  chk_plane_strobe: assert property (
    |plane_wr_out |-> mem_ack_out && $past(mem_wr_in))
    else $error("stray plane strobe");
  chk_clk_decode: assert property (
    clk_ext_sel_out == (clk_src_out == CLK_SRC_EXT) &&
    clk_sel_bad_out == (clk_src_out == 2'h3)) else $error("clock decode");
  chk_size_code: assert property (
    vert_lines_out == (vsync_pos_out ? (hsync_pos_out ? 10'h000 : LINES_400)
    : (hsync_pos_out ? LINES_350 : LINES_480))) else $error("line count");
  chk_blank_bw: assert property (
    blank_out == sys_bw_max_out) else $error("blank vs bandwidth");
  chk_load_on_tick: assert property (
    ser_load_out |-> char_tick_out) else $error("stray load");
endmodule
bind vseq_regs vseq_regs_monitor #(.PLANES(PLANES)) u_mon (.clk_in,
  .rstn_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_rdata_out, .io_ack_out,
  .mem_wr_in, .mem_rd_in, .plane_wr_out, .mem_ack_out, .frame_irq_pending_in,
  .mon_sense_in, .vretrace_in, .disp_en_in, .clk_src_out, .clk_ext_sel_out,
  .clk_sel_bad_out, .vert_lines_out, .vsync_pos_out, .hsync_pos_out,
  .crt_color_base_out, .blank_out, .sys_bw_max_out, .char_tick_out,
  .ser_load_out);

// ---- tb/vseq_regs_test.sv ----
// self-checking bench for the video sequencer register bank
`timescale 1ns/1ps
module vseq_regs_test
  import vseq_pkg::*;
;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00;
  logic io_wr = 1'b0, io_rd = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0;
  logic irq = 1'b0, sense = 1'b0, vretr = 1'b0, disp_en = 1'b1;
  logic alpha = 1'b1, attr3 = 1'b0, dot8 = 1'b0;
  logic [7:0] ccode = 8'h00;
  logic [7:0] io_rdata, rdata;
  logic [3:0] plane_wr;
  logic [1:0] clk_src;
  logic [9:0] lines;
  logic [2:0] fblk;
  logic io_ack, ack, mem_ack, ext_sel, sel_bad, vpos, hpos, base, run;
  logic blank, bw, tick, load, dot9;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] rst_seq [5] = '{RST_HALT, RST_CLOCKING, RST_PLANE_WE,
    RST_FONT, RST_MEM_MODE};
  logic [9:0] lines_tab [4] = '{10'h000, LINES_400, LINES_350, LINES_480};
  logic [7:0] cm [6] = '{8'h00, 8'h01, 8'h09, 8'h05, 8'h11, 8'h08};
  logic [7:0] cp [6] = '{8'h09, 8'h08, 8'h10, 8'h08, 8'h08, 8'h12};
  logic [7:0] lp [6] = '{8'h09, 8'h08, 8'h10, 8'h10, 8'h20, 8'h12};
  logic [2:0] blk [8] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1, 3'h3, 3'h5, 3'h7};
  logic [7:0] dc [5] = '{8'hc0, 8'hdf, 8'he0, 8'hbf, 8'hc0};
  logic [7:0] hv [3] = '{8'h01, 8'h02, 8'h00};

  always #2.5 clk_in = ~clk_in;

  vseq_regs DUT (.clk_in(clk_in), .rstn_in(rstn_in), .io_addr_in(io_addr),
    .io_wr_in(io_wr), .io_rd_in(io_rd), .io_wdata_in(io_wdata),
    .io_rdata_out(io_rdata), .io_ack_out(io_ack), .mem_wr_in(mem_wr),
    .mem_rd_in(mem_rd), .plane_wr_out(plane_wr), .mem_ack_out(mem_ack),
    .frame_irq_pending_in(irq), .mon_sense_in(sense), .vretrace_in(vretr),
    .disp_en_in(disp_en), .alpha_mode_in(alpha), .attr_b3_in(attr3),
    .char_code_in(ccode), .dot8_in(dot8), .clk_src_out(clk_src),
    .clk_ext_sel_out(ext_sel), .clk_sel_bad_out(sel_bad),
    .vert_lines_out(lines), .vsync_pos_out(vpos), .hsync_pos_out(hpos),
    .crt_color_base_out(base), .seq_run_out(run), .blank_out(blank),
    .sys_bw_max_out(bw), .char_tick_out(tick), .ser_load_out(load),
    .font_block_out(fblk), .dot9_out(dot9));
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // idle edge between accesses
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    step(1);
    io_wr = 1'b0;
    io_rd = 1'b0;
    rdata = io_rdata;
    ack = io_ack;
    step(1);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io(1'b1, a, d);
    chk("write ack", 16'h0001, ack);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    io(1'b0, a, 8'h00);
    chk("read ack", 16'h0001, ack);
    chk("read data", e, rdata);
  endtask
  task automatic sq(input logic [2:0] i, input logic [7:0] d);
    wr(PORT_SEQ_INDEX, {5'h00, i});
    wr(PORT_SEQ_DATA, d);
  endtask
  task automatic mem(input logic w, input logic ea, input logic [3:0] ep);
    mem_wr = w;
    mem_rd = !w;
    step(1);
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    chk("mem ack", ea, mem_ack);
    chk("plane strobes", ep, plane_wr);
    step(1);
  endtask
  // cycles between two rising edges
  task automatic gap(input logic s, output int p);
    logic cur, prev = 1'b1, st = 1'b0;
    p = 0;
    for (int n = 0; n < 400; n++) begin
      step(1);
      cur = s ? load : tick;
      p++;
      if (cur === 1'b1 && prev === 1'b0) begin
        if (st) return;
        st = 1'b1;
        p = 0;
      end
      prev = cur;
    end
    bad_count++;
    $display("MISMATCH pulse wait expected pulse seen none");
    report_and_stop;
  endtask
  task automatic t_reset;
    chk("vsync pos", 16'h0001, vpos);
    chk("seq run", 16'h0001, run);
    rd(PORT_DECODE_CTRL, 8'h01);
    rd(PORT_GEN_OUT_RD, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(PORT_SEQ_INDEX, i[7:0]);
      rd(PORT_SEQ_DATA, rst_seq[i]);
    end
    $display("test reset done");
  endtask
  task automatic t_gen_out;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], 2'b00, i[1:0], 2'b11};
      wr(PORT_GEN_OUT_WR, v);
      step(2);
      chk("clock source", i[1:0], clk_src);
      chk("external clock", i == 2, ext_sel);
      chk("reserved clock", i == 3, sel_bad);
      chk("lines", lines_tab[i], lines);
      chk("vsync pos", !i[1], vpos);
      chk("hsync pos", !i[0], hpos);
      rd(PORT_GEN_OUT_RD, v);
    end
    $display("test general output done");
  endtask
  task automatic t_ports;
    wr(PORT_GEN_OUT_WR, 8'h02);
    step(2);
    chk("color base", 16'h0000, base);
    vretr = 1'b1;
    rd(PORT_STATUS_B_MONO, 8'h08);
    io(1'b0, PORT_STATUS_B_COLOR, 8'h00);
    chk("unselected ack", 16'h0000, ack);
    wr(PORT_STATUS_B_MONO, 8'h5a);
    rd(PORT_FEATURE_RD, 8'h00);
    wr(PORT_GEN_OUT_WR, 8'h03);
    step(2);
    vretr = 1'b0;
    disp_en = 1'b0;
    rd(PORT_STATUS_B_COLOR, 8'h01);
    io(1'b1, PORT_STATUS_B_MONO, 8'h00);
    chk("unselected ack", 16'h0000, ack);
    disp_en = 1'b1;
    irq = 1'b1;
    rd(PORT_STATUS_A, 8'h80);
    irq = 1'b0;
    sense = 1'b1;
    rd(PORT_STATUS_A, 8'h10);
    $display("test ports done");
  endtask
  task automatic t_decode;
    wr(PORT_DECODE_CTRL, 8'h00);
    io(1'b0, PORT_STATUS_A, 8'h00);
    chk("io ack off", 16'h0000, ack);
    chk("io data off", 16'h0000, rdata);
    mem(1'b1, 1'b0, 4'h0);
    rd(PORT_DECODE_CTRL, 8'h00);
    wr(PORT_DECODE_CTRL, 8'h01);
    rd(PORT_STATUS_A, 8'h10);
    $display("test decode done");
  endtask
  task automatic t_mem;
    for (int m = 0; m < 16; m++) begin
      sq(IDX_PLANE_WE, m[7:0]);
      mem(1'b1, 1'b1, m[3:0]);
    end
    mem(1'b0, 1'b1, 4'h0);
    wr(PORT_GEN_OUT_WR, 8'h01);
    step(2);
    mem(1'b1, 1'b0, 4'h0);
    wr(PORT_GEN_OUT_WR, 8'h03);
    wr(PORT_SEQ_INDEX, 8'hfa);
    rd(PORT_SEQ_INDEX, 8'h02);
    rd(PORT_SEQ_DATA, 8'h0f);
    rd(PORT_SEQ_DATA, 8'h0f);
    $display("test memory done");
  endtask
  task automatic t_clock;
    int p;
    for (int k = 0; k < 6; k++) begin
      sq(IDX_HALT, 8'h01);
      sq(IDX_CLOCKING, cm[k]);
      sq(IDX_HALT, 8'h03);
      gap(1'b0, p);
      chk("char period", cp[k], p);
      gap(1'b1, p);
      chk("load period", lp[k], p);
    end
    sq(IDX_CLOCKING, 8'h21);
    step(2);
    chk("blank", 16'h0001, blank);
    chk("bandwidth", 16'h0001, bw);
    gap(1'b0, p);
    chk("char period blanked", 16'h0008, p);
    $display("test clocking done");
  endtask
  task automatic t_halt;
    int n, p;
    for (int k = 0; k < 3; k++) begin
      sq(IDX_HALT, hv[k]);
      step(12);
      chk("seq run", 16'h0000, run);
      n = 0;
      repeat (40) begin
        step(1);
        if (tick !== 1'b0) n++;
      end
      chk("ticks halted", 16'h0000, n);
    end
    sq(IDX_HALT, 8'h03);
    step(2);
    chk("seq run", 16'h0001, run);
    gap(1'b0, p);
    chk("char period", 16'h0008, p);
    $display("test halt done");
  endtask
  task automatic t_font;
    logic [2:0] a, b;
    sq(IDX_MEM_MODE, 8'h02);
    for (int c = 0; c < 8; c++) begin
      a = c[2:0];
      b = ~a;
      sq(IDX_FONT_SEL, {2'b00, a[2], b[2], a[1:0], b[1:0]});
      attr3 = 1'b1;
      step(3);
      chk("bank a block", blk[a], fblk);
      attr3 = 1'b0;
      step(3);
      chk("bank b block", blk[b], fblk);
    end
    attr3 = 1'b1;
    sq(IDX_MEM_MODE, 8'h00);
    step(3);
    chk("small memory block", 16'h0000, fblk);
    sq(IDX_CLOCKING, 8'h00);
    for (int k = 0; k < 5; k++) begin
      ccode = dc[k];
      dot8 = (k < 4);
      step(3);
      chk("ninth dot", k < 2, dot9);
    end
    dot8 = 1'b1;
    sq(IDX_CLOCKING, 8'h01);
    step(3);
    chk("ninth dot narrow", 16'h0000, dot9);
    $display("test font done");
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    step(3);
    t_reset;
    t_gen_out;
    t_ports;
    t_decode;
    t_mem;
    t_clock;
    t_halt;
    t_font;
    report_and_stop;
  end
endmodule
